// ---- src/ppc_top.sv ----
/*
 parallel port control top: register bus slave, transfer engine and
 pin shaper. assumes one 250 mhz clock, idle_req from the power logic
 and transfer requests from internal logic on the same clock.
*/
// Our own choices: the placing of the registers and register access over AXI4-Lite.
// Behaviour
// - 16-bit control word, bit layout
// - bit 15 turns the port on/off
// - idle stop bit halts port in idle
// - mux field: 10 full, 00 separate
// - bit 10 enables byte enable pin
// - bit 9 enables write strobe pin
// - bit 8 enables read strobe pin
// - chip select function 10 selects chip
// - bit 5 sets latch strobe polarity
// - polarities ignored when pins are address
`timescale 1ns/1ps
module ppc_top
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // axi4-lite slave
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // device state and transfer request
   input  wire logic        idle_req,
   input  wire logic        xfer_req,
   input  wire logic        xfer_write,
   input  wire logic [15:0] xfer_addr,
   input  wire logic [7:0]  xfer_wdata,
   output logic             xfer_busy,
   output logic             xfer_done,
   // pins
   output ppc_pins_s        pins
);
   typedef enum logic [2:0] {
      PPC_ST_IDLE  = 3'b000,
      PPC_ST_ALO   = 3'b001,
      PPC_ST_AHI   = 3'b010,
      PPC_ST_DATA  = 3'b011,
      PPC_ST_END   = 3'b100
   } ppc_state_e;

   logic [15:0] ctrl;
   logic [15:0] stat;
   ppc_state_e  state;
   ppc_state_e  next_state;
   ppc_req_s    req;
   ppc_req_s    next_req;
   logic        wr_q;
   logic [15:0] addr_q;
   logic [7:0]  data_q;

   ////////////////////////////////////////////////////////////////////
   // register bus
   ppc_axil u_axil (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .ctrl    (ctrl),
      .stat    (stat)
   );

   ////////////////////////////////////////////////////////////////////
   // decode
   wire       port_on   = ctrl[PPC_BIT_ON];
   wire [1:0] mux_sel   = ctrl[PPC_BIT_MUXHI:PPC_BIT_MUXLO];
   wire       halted    = idle_req && ctrl[PPC_BIT_IDLE];
   wire       run       = port_on && !halted;
   wire       mux_full  = (mux_sel == PPC_MUX_FULL);
   wire       mux_part  = (mux_sel == PPC_MUX_PARTIAL);
   wire       start     = run && xfer_req && (state == PPC_ST_IDLE);
   wire       first_st  = (mux_full || mux_part) ? 1'b1 : 1'b0;
   // request fields are loaded on the start edge, so bypass them then
   wire        cur_wr   = start ? xfer_write : wr_q;
   wire [15:0] cur_addr = start ? xfer_addr : addr_q;
   wire [7:0]  cur_data = start ? xfer_wdata : data_q;

   assign stat = {13'h0000, halted, run, xfer_busy};

   ////////////////////////////////////////////////////////////////////
   // transfer sequencer
   always_comb begin
      next_state = state;
      next_req   = '0;
      if (!run) begin
         next_state = PPC_ST_IDLE;
      end else begin
         case (state)
            PPC_ST_IDLE: begin
               if (start) begin
                  next_state = first_st ? PPC_ST_ALO : PPC_ST_DATA;
               end
            end
            PPC_ST_ALO: begin
               next_state = mux_full ? PPC_ST_AHI : PPC_ST_DATA;
            end
            PPC_ST_AHI: begin
               next_state = PPC_ST_DATA;
            end
            PPC_ST_DATA: begin
               next_state = PPC_ST_END;
            end
            PPC_ST_END: begin
               next_state = PPC_ST_IDLE;
            end
            default: begin
               next_state = PPC_ST_IDLE;
            end
         endcase
         case (next_state)
            PPC_ST_ALO: begin
               next_req.addr_phase_lo = 1'b1;
               next_req.data          = cur_addr[7:0];
               next_req.data_oe       = 1'b1;
            end
            PPC_ST_AHI: begin
               next_req.addr_phase_hi = 1'b1;
               next_req.data          = cur_addr[15:8];
               next_req.data_oe       = 1'b1;
            end
            PPC_ST_DATA: begin
               next_req.cycle   = 1'b1;
               next_req.sel     = 1'b1;
               next_req.be      = 1'b1;
               next_req.rd      = !cur_wr;
               next_req.wr      = cur_wr;
               next_req.data    = cur_wr ? cur_data : 8'h00;
               next_req.data_oe = cur_wr;
            end
            default: begin
               next_req = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q   <= 1'b0;
         addr_q <= 16'h0000;
         data_q <= 8'h00;
      end else if (start) begin
         wr_q   <= xfer_write;
         addr_q <= xfer_addr;
         data_q <= xfer_wdata;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state     <= PPC_ST_IDLE;
         req       <= '0;
         xfer_busy <= 1'b0;
         xfer_done <= 1'b0;
      end else begin
         state     <= next_state;
         req       <= next_req;
         xfer_busy <= (next_state != PPC_ST_IDLE);
         xfer_done <= run && (state == PPC_ST_END);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin shaping
   ppc_pins u_pins (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .ctrl    (ctrl),
      .req     (req),
      .pins    (pins)
   );

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_off_no_xfer;
      @(posedge mclk) disable iff (sys_rst)
         !port_on |=> state == PPC_ST_IDLE && !req.cycle;
   endproperty
   a_off_no_xfer: assert property (p_off_no_xfer)
      else $error("transfer while port off");

   property p_idle_halt;
      @(posedge mclk) disable iff (sys_rst)
         idle_req && ctrl[PPC_BIT_IDLE] |=> !xfer_busy;
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("port ran in idle with stop set");

   property p_full_mux;
      @(posedge mclk) disable iff (sys_rst)
         start && mux_full ##1 run
         |-> state == PPC_ST_ALO ##1 state == PPC_ST_AHI;
   endproperty
   a_full_mux: assert property (p_full_mux)
      else $error("full mux skipped high address");

   property p_sep_mux;
      @(posedge mclk) disable iff (sys_rst)
         start && mux_sel == PPC_MUX_SEPARATE |=> state == PPC_ST_DATA;
   endproperty
   a_sep_mux: assert property (p_sep_mux)
      else $error("separate mode used address phase");

   property p_cs_inactive;
      @(posedge mclk) disable iff (sys_rst)
         ctrl[PPC_BIT_ON] && !req.cycle && ctrl[7:6] == PPC_CSF_CHIP
         && $stable(ctrl) |=> pins.chip_select_pin == !$past(ctrl[3]);
   endproperty
   a_cs_inactive: assert property (p_cs_inactive)
      else $error("chip select not at idle level");

   property p_latch_pol;
      @(posedge mclk) disable iff (sys_rst)
         req.addr_phase_lo && mux_sel != PPC_MUX_SEPARATE && $stable(ctrl)
         |=> pins.low_addr_latch == $past(ctrl[5]);
   endproperty
   a_latch_pol: assert property (p_latch_pol)
      else $error("low latch polarity wrong");
endmodule // ppc_top

// ---- inc/ppc_pkg.sv ----
/*
 parallel port control package: register offsets, field positions,
 reset values, mode codes and the pin bundle struct.
 assumes a 32-bit axi4-lite register bus.
*/
package ppc_pkg;
   localparam logic [3:0]  PPC_OFS_CTRL    = 4'h0;
   localparam logic [3:0]  PPC_OFS_STAT    = 4'h4;
   localparam logic [15:0] PPC_CTRL_RST    = 16'h0000;
   localparam logic [15:0] PPC_CTRL_WMASK  = 16'hbfef;
   localparam int          PPC_BIT_ON      = 15;
   localparam int          PPC_BIT_IDLE    = 13;
   localparam int          PPC_BIT_MUXHI   = 12;
   localparam int          PPC_BIT_MUXLO   = 11;
   localparam int          PPC_BIT_BEEN    = 10;
   localparam int          PPC_BIT_WREN    = 9;
   localparam int          PPC_BIT_RDEN    = 8;
   localparam int          PPC_BIT_CSFHI   = 7;
   localparam int          PPC_BIT_CSFLO   = 6;
   localparam int          PPC_BIT_ALP     = 5;
   localparam int          PPC_BIT_CSP     = 3;
   localparam int          PPC_BIT_BEP     = 2;
   localparam int          PPC_BIT_WRP     = 1;
   localparam int          PPC_BIT_RDP     = 0;
   localparam logic [1:0]  PPC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PPC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PPC_MUX_SEPARATE = 2'b00,
      PPC_MUX_PARTIAL  = 2'b01,
      PPC_MUX_FULL     = 2'b10,
      PPC_MUX_RESVD    = 2'b11
   } ppc_mux_e;

   typedef enum logic [1:0] {
      PPC_CSF_NONE0 = 2'b00,
      PPC_CSF_NONE1 = 2'b01,
      PPC_CSF_CHIP  = 2'b10,
      PPC_CSF_RESVD = 2'b11
   } ppc_csf_e;

   // drive requests from the transfer engine
   typedef struct packed {
      logic       cycle;
      logic       addr_phase_lo;
      logic       addr_phase_hi;
      logic       rd;
      logic       wr;
      logic       be;
      logic       sel;
      logic [7:0] data;
      logic       data_oe;
   } ppc_req_s;

   // pin bundle, oe low means the pin is driven
   typedef struct packed {
      logic [7:0] port_data_pins;
      logic       port_data_oe_n;
      logic       write_strobe_pin;
      logic       write_strobe_oe_n;
      logic       read_strobe_pin;
      logic       read_strobe_oe_n;
      logic       byte_enable_pin;
      logic       byte_enable_oe_n;
      logic       chip_select_pin;
      logic       chip_select_oe_n;
      logic       low_addr_latch;
      logic       high_addr_latch;
   } ppc_pins_s;
endpackage

// ---- src/ppc_axil.sv ----
/*
 axi4-lite slave for the port control word and a status word.
 assumes one clock and a master that holds valid until ready.
*/
`timescale 1ns/1ps
module ppc_axil
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // axi4-lite
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // register side
   output logic [15:0]      ctrl,
   input  wire logic [15:0] stat
);
   logic [3:0]  aw_q;
   logic        aw_have;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic        w_have;
   wire         do_wr   = aw_have && w_have && !bvalid;
   wire         wr_ctrl = do_wr && (aw_q == PPC_OFS_CTRL);
   wire         wr_ok   = (aw_q == PPC_OFS_CTRL) || (aw_q == PPC_OFS_STAT);
   wire  [15:0] lane_m  = {{8{ws_q[1]}}, {8{ws_q[0]}}};
   wire  [15:0] wmask   = lane_m & PPC_CTRL_WMASK;
   wire  [15:0] next_ctrl = (ctrl & ~wmask) | (wd_q[15:0] & wmask);
   wire         rd_ok   = (araddr == PPC_OFS_CTRL) ||
                          (araddr == PPC_OFS_STAT);
   wire  [15:0] rd_val  = (araddr == PPC_OFS_CTRL) ? ctrl : stat;

   assign awready = !aw_have;
   assign wready  = !w_have;
   assign arready = !rvalid;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_have <= 1'b0;
         w_have  <= 1'b0;
         aw_q    <= 4'h0;
         wd_q    <= 32'h0000_0000;
         ws_q    <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= PPC_RESP_OKAY;
         ctrl    <= PPC_CTRL_RST;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= PPC_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_q    <= awaddr;
            aw_have <= 1'b1;
         end
         if (wvalid && wready) begin
            wd_q   <= wdata;
            ws_q   <= wstrb;
            w_have <= 1'b1;
         end
         if (do_wr) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (wr_ctrl) begin
            ctrl <= next_ctrl;
         end
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_ok ? {16'h0000, rd_val} : 32'h0000_0000;
            rresp  <= rd_ok ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   property p_reserved_zero;
      @(posedge mclk) disable iff (sys_rst)
         ctrl[14] == 1'b0 && ctrl[4] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved control bits set");

   property p_ctrl_write;
      @(posedge mclk) disable iff (sys_rst)
         wr_ctrl && (&ws_q[1:0]) |=> ctrl == (wd_q[15:0] & PPC_CTRL_WMASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control word not stored");
endmodule // ppc_axil

// ---- src/ppc_pins.sv ----
/*
 pin shaper: applies enables and polarities to the transfer requests.
 assumes requests arrive registered on mclk.
*/
`timescale 1ns/1ps
module ppc_pins
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // settings and requests
   input  wire logic [15:0] ctrl,
   input  wire ppc_req_s    req,
   // pins
   output ppc_pins_s        pins
);
   wire       on     = ctrl[PPC_BIT_ON];
   wire [1:0] mux    = ctrl[PPC_BIT_MUXHI:PPC_BIT_MUXLO];
   wire       cs_fn  = (ctrl[PPC_BIT_CSFHI:PPC_BIT_CSFLO] == PPC_CSF_CHIP);
   wire       al_pol = ctrl[PPC_BIT_ALP];
   wire       cs_pol = ctrl[PPC_BIT_CSP];
   wire       cs_act = on && cs_fn && req.cycle && req.sel;
   wire       alo    = on && req.addr_phase_lo;
   wire       ahi    = on && req.addr_phase_hi;
   ppc_pins_s next_pins;

   always_comb begin
      next_pins = '0;
      next_pins.port_data_pins    = on ? req.data : 8'h00;
      next_pins.port_data_oe_n    = !(on && req.data_oe);
      next_pins.write_strobe_oe_n = !(on && ctrl[PPC_BIT_WREN]);
      next_pins.write_strobe_pin  = (on && req.wr) ^ !ctrl[PPC_BIT_WRP];
      next_pins.read_strobe_oe_n  = !(on && ctrl[PPC_BIT_RDEN]);
      next_pins.read_strobe_pin   = (on && req.rd) ^ !ctrl[PPC_BIT_RDP];
      next_pins.byte_enable_oe_n  = !(on && ctrl[PPC_BIT_BEEN]);
      next_pins.byte_enable_pin   = (on && req.be) ^ !ctrl[PPC_BIT_BEP];
      // polarity only matters when the pin is not an address line
      next_pins.chip_select_oe_n  = !(on && cs_fn);
      next_pins.chip_select_pin   = cs_fn ? (cs_act ~^ cs_pol) : 1'b0;
      next_pins.low_addr_latch    = (mux != PPC_MUX_SEPARATE) ?
                                    (alo ~^ al_pol) : 1'b0;
      next_pins.high_addr_latch   = (mux != PPC_MUX_SEPARATE) ?
                                    (ahi ~^ al_pol) : 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pins <= '{default: 1'b0, port_data_oe_n: 1'b1,
                   write_strobe_oe_n: 1'b1, read_strobe_oe_n: 1'b1,
                   byte_enable_oe_n: 1'b1, chip_select_oe_n: 1'b1};
      end else begin
         pins <= next_pins;
      end
   end

   property p_off_quiet;
      @(posedge mclk) disable iff (sys_rst)
         !ctrl[PPC_BIT_ON] |=> pins.port_data_oe_n && pins.chip_select_oe_n;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("pins driven while port off");

   property p_wr_en;
      @(posedge mclk) disable iff (sys_rst)
         ctrl[PPC_BIT_ON] && !ctrl[PPC_BIT_WREN] |=> pins.write_strobe_oe_n;
   endproperty
   a_wr_en: assert property (p_wr_en)
      else $error("write strobe driven while disabled");
endmodule // ppc_pins

// ---- tb/ppc_ext_dev.sv ----
/*
 behavioural external parallel device watching the port pins.
 assumes strobe polarity bits set, so strobes read active high.
*/
`timescale 1ns/1ps
module ppc_ext_dev
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic      mclk,
   input  wire logic      sys_rst,
   // board strapping
   input  wire logic      cs_high,
   input  wire logic      latch_high,
   // port pins
   input  wire ppc_pins_s pins,
   // traffic seen
   output logic [15:0]    addr_seen,
   output logic [7:0]     data_seen,
   output logic [7:0]     wr_cnt,
   output logic [7:0]     rd_cnt
);
////////////////////////////////////////
   logic sel;
   logic wr_on;
   logic rd_on;
   logic wr_q;
   logic rd_q;
   // undriven select line is strapped active
   assign sel = pins.chip_select_oe_n
              | (pins.chip_select_pin == cs_high);
   assign wr_on = sel & ~pins.write_strobe_oe_n
                & pins.write_strobe_pin;
   assign rd_on = sel & ~pins.read_strobe_oe_n
                & pins.read_strobe_pin;
////////////////////////////////////////
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_seen <= 16'h0000;
         data_seen <= 8'h00;
         wr_cnt <= 8'h00;
         rd_cnt <= 8'h00;
         wr_q <= 1'h0;
         rd_q <= 1'h0;
      end else begin
         wr_q <= wr_on;
         rd_q <= rd_on;
         if (pins.low_addr_latch == latch_high) begin
            addr_seen[7:0] <= pins.port_data_pins;
         end
         if (pins.high_addr_latch == latch_high) begin
            addr_seen[15:8] <= pins.port_data_pins;
         end
         if (wr_on) begin
            data_seen <= pins.port_data_pins;
         end
         if (wr_on & ~wr_q) begin
            wr_cnt <= wr_cnt + 8'h01;
         end
         if (rd_on & ~rd_q) begin
            rd_cnt <= rd_cnt + 8'h01;
         end
      end
   end
endmodule // ppc_ext_dev

// ---- tb/ppc_top_tb.sv ----
/*
 self-checking bench for the parallel port control top.
 assumes the device model ppc_ext_dev on the pins.
*/
`timescale 1ns/1ps
module ppc_top_tb
   import ppc_pkg::*;
;
////////////////////////////////////////
   logic        mclk, sys_rst, idle_req;
   logic [3:0]  awaddr, araddr, wstrb;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        xfer_req, xfer_write, xfer_busy, xfer_done;
   logic [15:0] xfer_addr, addr_seen;
   logic [7:0]  xfer_wdata, data_seen, wr_cnt, rd_cnt;
   logic        cs_high, latch_high;
   ppc_pins_s   pins;
   int          err_count, n_checks;

   ppc_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .idle_req(idle_req), .xfer_req(xfer_req),
      .xfer_write(xfer_write), .xfer_addr(xfer_addr),
      .xfer_wdata(xfer_wdata), .xfer_busy(xfer_busy),
      .xfer_done(xfer_done), .pins(pins));

   ppc_ext_dev dev_u (.mclk(mclk), .sys_rst(sys_rst), .cs_high(cs_high),
      .latch_high(latch_high), .pins(pins), .addr_seen(addr_seen),
      .data_seen(data_seen), .wr_cnt(wr_cnt), .rd_cnt(rd_cnt));

   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tmo();
      err_count++;
      $display("CHECK FAILED bus wait expected answer seen none");
      tally_and_finish();
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic ha, hw, got;
      got = 1'h0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(negedge mclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         got = (bvalid === 1'h1);
         r = bresp;
         @(posedge mclk);
         if (ha) awvalid <= 1'h0;
         if (hw) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      if (!got) tmo();
      @(posedge mclk);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic ha, got;
      got = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(negedge mclk);
         ha = arvalid & arready;
         got = (rvalid === 1'h1);
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (ha) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      if (!got) tmo();
      @(posedge mclk);
   endtask

   // lat: negedges from take edge to done, 0 if none; drv: pins driven
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output int lat,
                       output logic [4:0] drv);
      lat = 0;
      drv = 5'h00;
      xfer_req <= 1'h1;
      xfer_write <= w;
      xfer_addr <= a;
      xfer_wdata <= d;
      @(posedge mclk);
      xfer_req <= 1'h0;
      for (int n = 1; n <= 12 && lat == 0; n++) begin
         @(negedge mclk);
         drv = drv | ~{pins.port_data_oe_n, pins.write_strobe_oe_n,
            pins.read_strobe_oe_n, pins.byte_enable_oe_n,
            pins.chip_select_oe_n};
         if (xfer_done === 1'h1) lat = n;
      end
      @(posedge mclk);
   endtask
////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(4'h0, d, r);
      chk("ctrl reset", 32'h0000_0000, d);
      axi_wr(4'h0, 32'hffff_ffff, r);
      chk("ctrl write resp", 32'h0, r);
      axi_rd(4'h0, d, r);
      chk("ctrl readback", 32'h0000_bfef, d);
      axi_rd(4'h8, d, r);
      chk("unmapped read resp", 32'h2, r);
      chk("unmapped read data", 32'h0, d);
      axi_wr(4'hc, 32'h1, r);
      chk("unmapped write resp", 32'h2, r);
   endtask

   task automatic t_off();
      logic [1:0] r;
      logic [4:0] drv;
      int         lat;
      axi_wr(4'h0, 32'h078f, r);
      xfer(1'h1, 16'h0042, 8'h3c, lat, drv);
      chk("off done", 0, lat);
      chk("off pins", 5'h00, drv);
   endtask

   task automatic t_sep();
      logic [1:0] r;
      logic [4:0] drv;
      logic [7:0] c0;
      int         lat;
      axi_wr(4'h0, 32'h878f, r);
      c0 = wr_cnt;
      xfer(1'h1, 16'h1234, 8'ha5, lat, drv);
      chk("sep latency", 3, lat);
      chk("sep pins", 5'h1f, drv);
      chk("sep data", 8'ha5, data_seen);
      chk("sep writes", c0 + 8'h01, wr_cnt);
      c0 = rd_cnt;
      xfer(1'h0, 16'h0055, 8'h00, lat, drv);
      chk("sep reads", c0 + 8'h01, rd_cnt);
   endtask

   task automatic t_mux();
      logic [1:0]  r;
      logic [4:0]  drv;
      logic [7:0]  c0;
      logic [15:0] a;
      int          lat;
      for (int p = 1; p >= 0; p--) begin
         axi_wr(4'h0, (p == 1) ? 32'h97af : 32'h9787, r);
         cs_high <= p[0];
         latch_high <= p[0];
         a = (p == 1) ? 16'hbeef : 16'h1357;
         c0 = wr_cnt;
         xfer(1'h1, a, 8'h6e, lat, drv);
         chk("mux latency", 5, lat);
         chk("mux address", a, addr_seen);
         chk("mux writes", c0 + 8'h01, wr_cnt);
      end
   endtask

   task automatic t_pins_off();
      logic [1:0] r;
      logic [4:0] drv;
      int         lat;
      axi_wr(4'h0, 32'h8007, r);
      xfer(1'h1, 16'h0101, 8'h5a, lat, drv);
      chk("bare latency", 3, lat);
      chk("bare pins", 5'h10, drv);
   endtask

   task automatic t_idle();
      logic [1:0] r;
      logic [4:0] drv;
      int         lat;
      axi_wr(4'h0, 32'ha78f, r);
      idle_req <= 1'h1;
      xfer(1'h1, 16'h0202, 8'h11, lat, drv);
      chk("idle stop done", 0, lat);
      axi_wr(4'h0, 32'h878f, r);
      xfer(1'h1, 16'h0303, 8'h22, lat, drv);
      chk("idle run latency", 3, lat);
      idle_req <= 1'h0;
   endtask
////////////////////////////////////////
   initial begin
      sys_rst = 1'h1;
      idle_req = 1'h0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wstrb = 4'h0;
      wdata = 32'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {xfer_req, xfer_write} = 2'h0;
      xfer_addr = 16'h0000;
      xfer_wdata = 8'h00;
      cs_high = 1'h1;
      latch_high = 1'h1;
      err_count = 0;
      n_checks = 0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'h0;
      @(posedge mclk);
      t_regs();
      t_off();
      t_sep();
      t_mux();
      t_pins_off();
      t_idle();
      tally_and_finish();
   end
endmodule // ppc_top_tb
